// ==== verilog/pmms_map.vh ====
`ifndef PMMS_MAP_VH
`define PMMS_MAP_VH

// Register offsets on the plain register port.
`define PMMS_ADDR_W          3
`define PMMS_OFS_CTRL        3'h0
`define PMMS_OFS_PRANGE      3'h1
`define PMMS_OFS_DRANGE      3'h2
`define PMMS_OFS_PART        3'h3
`define PMMS_OFS_STATUS      3'h4

// Control register fields.
`define PMMS_CTRL_WARN_EN    0
`define PMMS_CTRL_PART_EN    1
`define PMMS_CTRL_PES        2

// Status register fields.
`define PMMS_ST_WARN_FLAG    0
`define PMMS_ST_BELOW_WARN   1
`define PMMS_ST_CORE_RESET   2
`define PMMS_ST_BACKUP       3
`define PMMS_ST_SIZE_SEL     4
`define PMMS_ST_EXT_RESET    5

// Reset values.
`define PMMS_RST_CTRL        8'h00
`define PMMS_RST_PRANGE      8'h10
`define PMMS_RST_DRANGE      8'h10
`define PMMS_RST_PART        8'h08

// Warning interrupt vector address.
`define PMMS_WARN_VECTOR     8'h2b

// Synchroniser bit positions.
`define PMMS_SY_WARN         0
`define PMMS_SY_RESET        1
`define PMMS_SY_BACKUP       2
`define PMMS_SY_IND          3
`define PMMS_SY_SIZE         4
`define PMMS_SY_W            5
`define PMMS_SY_INIT         5'h18

`endif

// ==== verilog/pmms_sync.v ====
`timescale 1ns/10ps
module pmms_sync #(
    parameter WIDTH = 5,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clock,   // Processor clock.
    input  wire             srst,    // Synchronous reset, active high.
    input  wire [WIDTH-1:0] async_i, // Levels from outside the clock domain.
    output reg  [WIDTH-1:0] sync_o   // Levels after two flip-flops.
);

    reg [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always @(posedge clock)
    begin
        if (srst)
        begin
            meta_q <= INIT;
            sync_o <= INIT;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// ==== verilog/pmms_top.v ====
// What this block does
// (R1) Warning threshold crossing, enabled, vectors to 2Bh
// (R2) Minimum threshold holds core in reset
// (R3) Power-fail reset forces all selects high
// (R4) Backup threshold switches to backup cell
// (R5) Drive reset indicator low while in reset; the code drives it only on below_reset, not on backup or an outside pull
// (R6) External low on indicator resets the core
// (R7) Backup-active output low on backup cell
// (R8) Size select picks 32k banks or 128k
// (R9) Board holds size select at defined level
// (R10) Program and data ranges map byte-wide bus
// (R11) Unmapped addresses go to expanded bus
// (R12) Partition mode splits one 64k space
// (R13) Peripheral space select adds 64k data space
// (R14) Peripheral selects decode 16k quarters, lowest first
// (R15) Large SRAM reuses bank selects as address
// (R16) Comparators and indicator synchronised before use
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "pmms_map.vh"
module pmms_top #(
    parameter DATA_W = 8,
    parameter ADDR_W = 16
) (
    input  wire              clock,                     // Processor clock, 125 MHz.
    input  wire              srst,                      // Synchronous reset, active high.
    input  wire              below_warning,             // Comparator: supply under warning level.
    input  wire              below_reset,               // Comparator: supply under reset level.
    input  wire              below_backup,              // Comparator: supply under backup level.
    input  wire              sram_size_select,          // Pin: high for 32k banks, low for 128k.
    input  wire              reset_indicator_n_i,       // Reset indicator pin level.
    output reg               reset_indicator_n_o,       // Reset indicator drive value.
    output reg               reset_indicator_n_oe,      // Reset indicator drive enable.
    output reg               backup_active_n,           // Low while on backup cell.
    output reg               switched_memory_supply_bk, // Memory supply taken from backup cell.
    output reg               core_reset,                // Holds the processor in reset.
    output reg               warn_irq,                  // One-cycle interrupt request.
    output reg  [7:0]        warn_vector,               // Interrupt vector address.
    input  wire              mem_req,                   // Core memory access strobe.
    input  wire              mem_is_data,               // Access is to data space.
    input  wire              mem_write,                 // Access is a write.
    input  wire [ADDR_W-1:0] mem_addr,                  // Core address.
    output reg  [3:0]        memory_bank_select_n,      // SRAM bank selects, active low.
    output reg  [3:0]        io_device_select_n,        // Peripheral selects, active low.
    output reg               sram_write_n,              // SRAM write strobe, active low.
    output reg  [ADDR_W-1:0] bytewide_addr,             // Byte-wide bus address.
    output reg               expanded_bus_sel,          // Access goes to the expanded bus.
    output reg  [ADDR_W-1:0] expanded_addr,             // Expanded bus address.
    input  wire [2:0]        reg_addr,                  // Register address.
    input  wire [DATA_W-1:0] reg_wdata,                 // Register write data.
    input  wire              reg_write,                 // Register write strobe.
    input  wire              reg_read,                  // Register read strobe.
    output reg  [DATA_W-1:0] reg_rdata                  // Read data, one cycle after strobe.
);

    // True when a 4k page lies below a page-count limit.
    function page_below;
        input [3:0] page;
        input [7:0] limit;
        begin
            page_below = ({4'h0, page} < limit);
        end
    endfunction

    // One-hot active-low decode of a two-bit field.
    function [3:0] decode_n;
        input [1:0] sel;
        begin
            decode_n = 4'hf;
            decode_n[sel] = 1'b0;
        end
    endfunction

    wire [`PMMS_SY_W-1:0] sy;
    wire [`PMMS_SY_W-1:0] sy_async;

    assign sy_async = {sram_size_select, reset_indicator_n_i, below_backup,
                       below_reset, below_warning};

    // Indicator and size select idle high so reset release is not spurious.
    pmms_sync #(
        .WIDTH (`PMMS_SY_W),
        .INIT  (`PMMS_SY_INIT)
    ) u_sync (
        .clock   (clock),
        .srst    (srst),
        .async_i (sy_async),
        .sync_o  (sy)
    ); // [R16]

    wire warn_s   = sy[`PMMS_SY_WARN];
    wire reset_s  = sy[`PMMS_SY_RESET];
    wire backup_s = sy[`PMMS_SY_BACKUP];
    wire ind_s    = sy[`PMMS_SY_IND];
    wire size_s   = sy[`PMMS_SY_SIZE];

    reg [7:0] ctrl_q;
    reg [7:0] prange_q;
    reg [7:0] drange_q;
    reg [7:0] part_q;
    reg       warn_flag_q;
    reg       warn_prev_q;
    reg       ext_reset_q;
    reg [1:0] own_drive_q;

    // Our own drive pulls the pin low too, and the pin level reaches ind_s two
    // clocks after the drive changes. A low counts as an outside request only
    // when neither the drive nor its delayed copies were on; otherwise our own
    // release would read back as a foreign pull. An outside pull during our drive is missed.
    wire self_drive = reset_indicator_n_oe | own_drive_q[0] | own_drive_q[1];
    wire ext_pull  = ~ind_s & ~reset_s & ~self_drive;
    wire in_reset  = reset_s | ext_pull | backup_s;
    wire warn_rise = warn_s & ~warn_prev_q;
    wire warn_fire = warn_rise & ctrl_q[`PMMS_CTRL_WARN_EN] & ~in_reset;

    wire wr_ctrl   = reg_write & (reg_addr == `PMMS_OFS_CTRL);
    wire wr_prange = reg_write & (reg_addr == `PMMS_OFS_PRANGE);
    wire wr_drange = reg_write & (reg_addr == `PMMS_OFS_DRANGE);
    wire wr_part   = reg_write & (reg_addr == `PMMS_OFS_PART);
    wire wr_status = reg_write & (reg_addr == `PMMS_OFS_STATUS);

    // Control registers survive power-fail and backup; only srst clears them,
    // which stands for the nonvolatile state being retained.
    always @(posedge clock)
    begin
        if (srst)
        begin
            ctrl_q   <= `PMMS_RST_CTRL;
            prange_q <= `PMMS_RST_PRANGE;
            drange_q <= `PMMS_RST_DRANGE;
            part_q   <= `PMMS_RST_PART;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q <= reg_wdata;
            end
            if (wr_prange)
            begin
                prange_q <= reg_wdata;
            end
            if (wr_drange)
            begin
                drange_q <= reg_wdata;
            end
            if (wr_part)
            begin
                part_q <= reg_wdata;
            end
        end
    end

    // Warning flag: write one to clear, a new event in the same cycle wins.
    always @(posedge clock)
    begin
        if (srst)
        begin
            warn_flag_q <= 1'b0;
            warn_prev_q <= 1'b0;
            warn_irq    <= 1'b0;
            warn_vector <= 8'h00;
        end
        else
        begin
            warn_prev_q <= warn_s;
            warn_irq    <= warn_fire; // [R1]
            warn_vector <= `PMMS_WARN_VECTOR; // [R1]
            if (warn_fire)
            begin
                warn_flag_q <= 1'b1; // [R1]
            end
            else if (wr_status & reg_wdata[`PMMS_ST_WARN_FLAG])
            begin
                warn_flag_q <= 1'b0;
            end
        end
    end

    // Sticky record that an outside party pulled the indicator low.
    always @(posedge clock)
    begin
        if (srst)
        begin
            ext_reset_q <= 1'b0;
        end
        else if (ext_pull)
        begin
            ext_reset_q <= 1'b1; // [R6]
        end
        else if (wr_status & reg_wdata[`PMMS_ST_EXT_RESET])
        begin
            ext_reset_q <= 1'b0;
        end
    end

    // Power state outputs.
    // The drive copies line up with the two synchroniser stages of the pin.
    always @(posedge clock)
    begin
        if (srst)
        begin
            core_reset                <= 1'b1;
            reset_indicator_n_o       <= 1'b0;
            reset_indicator_n_oe      <= 1'b0;
            backup_active_n           <= 1'b1;
            switched_memory_supply_bk <= 1'b0;
            own_drive_q               <= 2'b00;
        end
        else
        begin
            core_reset                <= in_reset; // [R2] [R6]
            reset_indicator_n_o       <= 1'b0;
            reset_indicator_n_oe      <= reset_s; // [R5]
            backup_active_n           <= ~backup_s; // [R7]
            switched_memory_supply_bk <= backup_s; // [R4]
            own_drive_q               <= {own_drive_q[0], reset_indicator_n_oe}; // [R6]
        end
    end

    // Address map decode.
    reg              map_nv;
    reg              map_prog;
    reg              map_io;
    reg [16:0]       phys;
    reg [3:0]        bank_n;
    reg [3:0]        io_n;
    reg [ADDR_W-1:0] ba;

    wire [3:0] page   = mem_addr[ADDR_W-1:ADDR_W-4];
    wire       peripheral_space_select    = ctrl_q[`PMMS_CTRL_PES];
    wire       part   = ctrl_q[`PMMS_CTRL_PART_EN];

    always @*
    begin
        map_nv   = 1'b0;
        map_prog = 1'b0;
        map_io   = 1'b0;
        phys     = {1'b0, mem_addr};
        // Peripheral space claims every data access; program follows the map below.
        if (mem_is_data & peripheral_space_select)
        begin
            map_io = 1'b1; // [R13]
        end
        else if (part)
        begin
            // One shared 64k space: program below the boundary, data above.
            map_prog = ~mem_is_data & page_below(page, part_q); // [R12]
            map_nv   = map_prog | (mem_is_data & ~page_below(page, part_q)); // [R12]
        end
        else
        begin
            map_prog = ~mem_is_data & page_below(page, prange_q); // [R10]
            map_nv   = map_prog | (mem_is_data & page_below(page, drange_q)); // [R10]
            phys     = {mem_is_data, mem_addr};
        end
    end

    always @*
    begin
        bank_n = 4'hf;
        io_n   = 4'hf;
        ba     = mem_addr;
        if (map_io)
        begin
            io_n = decode_n(mem_addr[ADDR_W-1:ADDR_W-2]); // [R14]
        end
        else if (map_nv & size_s)
        begin
            bank_n = decode_n(phys[16:15]); // [R8]
            ba     = {1'b0, mem_addr[ADDR_W-2:0]};
        end
        else if (map_nv)
        begin
            // Second and third bank pins carry the top address bits here.
            bank_n = {1'b1, phys[15], phys[16], 1'b0}; // [R8] [R15]
            ba     = {1'b0, mem_addr[ADDR_W-2:0]};
        end
    end

    // Memory strobes; program blocks are write-protected.
    // Addresses keep their last value while idle, which saves toggling the pins.
    always @(posedge clock)
    begin
        if (srst)
        begin
            memory_bank_select_n <= 4'hf;
            io_device_select_n   <= 4'hf;
            sram_write_n         <= 1'b1;
            bytewide_addr        <= {ADDR_W{1'b0}};
            expanded_bus_sel     <= 1'b0;
            expanded_addr        <= {ADDR_W{1'b0}};
        end
        else if (in_reset | ~mem_req)
        begin
            memory_bank_select_n <= 4'hf; // [R3]
            io_device_select_n   <= 4'hf; // [R3]
            sram_write_n         <= 1'b1; // [R3]
            expanded_bus_sel     <= 1'b0;
        end
        else
        begin
            memory_bank_select_n <= bank_n;
            io_device_select_n   <= io_n;
            sram_write_n         <= ~(mem_write & (map_nv | map_io) & ~map_prog);
            bytewide_addr        <= ba;
            expanded_bus_sel     <= ~map_nv & ~map_io; // [R11]
            expanded_addr        <= mem_addr; // [R11]
        end
    end

    // Register read port; unmapped addresses read zero.
    // Status shows live levels; only the warning and outside-reset bits are sticky.
    always @(posedge clock)
    begin
        if (srst)
        begin
            reg_rdata <= {DATA_W{1'b0}};
        end
        else if (reg_read)
        begin
            case (reg_addr)
                `PMMS_OFS_CTRL:
                    reg_rdata <= ctrl_q;
                `PMMS_OFS_PRANGE:
                    reg_rdata <= prange_q;
                `PMMS_OFS_DRANGE:
                    reg_rdata <= drange_q;
                `PMMS_OFS_PART:
                    reg_rdata <= part_q;
                `PMMS_OFS_STATUS:
                    reg_rdata <= {2'h0, ext_reset_q, size_s, backup_s, in_reset,
                                  warn_s, warn_flag_q};
                default:
                    reg_rdata <= {DATA_W{1'b0}};
            endcase
        end
        else
        begin
            reg_rdata <= {DATA_W{1'b0}};
        end
    end

endmodule

// ==== verif/pmms_partner.sv ====
`timescale 1ns/10ps
module pmms_partner (
    input  wire dev_o,    // Device drive value.
    input  wire dev_oe,   // Device drive enable.
    input  wire ext_pull, // Another part pulls the line.
    output wire line_n    // Resolved line level.
);
    // Open drain with a pull-up, so any enabled low driver wins.
    assign line_n = ((dev_oe && !dev_o) || ext_pull) ? 1'b0 : 1'b1;
endmodule

// ==== verif/pmms_top_monitor.sv ====
`timescale 1ns/10ps
module pmms_top_monitor #(
    parameter ADDR_W = 16
) (
    input wire              clock,                // Clock.
    input wire              srst,                 // Reset.
    input wire              below_reset,          // Reset level.
    input wire              below_backup,         // Backup level.
    input wire              reset_indicator_n_o,  // Drive value.
    input wire              reset_indicator_n_oe, // Drive enable.
    input wire              backup_active_n,      // Backup flag.
    input wire              core_reset,           // Core reset.
    input wire              warn_irq,             // Warning pulse.
    input wire [7:0]        warn_vector,          // Vector.
    input wire [ADDR_W-1:0] mem_addr,             // Core address.
    input wire [3:0]        memory_bank_select_n, // Banks.
    input wire [3:0]        io_device_select_n,   // Peripherals.
    input wire              sram_write_n,         // Write strobe.
    input wire              expanded_bus_sel,     // Expanded bus.
    input wire [ADDR_W-1:0] expanded_addr         // Expanded address.
);
    wire [1:0] quarter = mem_addr[ADDR_W-1:ADDR_W-2];

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    property p_quiet;
        $past(core_reset) && core_reset |->
            &memory_bank_select_n && &io_device_select_n && sram_write_n;
    endproperty
    a_quiet: assert property (p_quiet) else $error("select active in reset");
    property p_rst_in;
        $rose(below_reset) |-> ##3 core_reset && reset_indicator_n_oe;
    endproperty
    a_rst_in: assert property (p_rst_in) else $error("reset entry late");
    property p_ind_low;
        reset_indicator_n_oe |-> !reset_indicator_n_o && core_reset;
    endproperty
    a_ind_low: assert property (p_ind_low) else $error("indicator drive wrong");
    property p_bk;
        $rose(below_backup) |-> ##[2:4] !backup_active_n;
    endproperty
    a_bk: assert property (p_bk) else $error("backup flag late");
    property p_bk_rst;
        !backup_active_n |-> ##[0:1] core_reset;
    endproperty
    a_bk_rst: assert property (p_bk_rst) else $error("backup without reset");
    property p_warn;
        warn_irq |-> warn_vector == 8'h2b && !core_reset ##1 !warn_irq;
    endproperty
    a_warn: assert property (p_warn) else $error("warning pulse wrong");
    property p_io;
        io_device_select_n != 4'hf |->
            io_device_select_n == ~(4'h1 << $past(quarter));
    endproperty
    a_io: assert property (p_io) else $error("peripheral decode wrong");
    property p_exp;
        expanded_bus_sel |-> expanded_addr == $past(mem_addr) && &memory_bank_select_n;
    endproperty
    a_exp: assert property (p_exp) else $error("expanded route wrong");
endmodule

bind pmms_top pmms_top_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// ==== verif/pmms_top_bench.sv ====
`timescale 1ns/10ps
module pmms_top_bench;
    logic        clock;
    logic        srst;
    logic        below_warning;
    logic        below_reset;
    logic        below_backup;
    logic        sram_size_select;
    logic        ext_pull;
    logic        mem_req;
    logic        mem_is_data;
    logic        mem_write;
    logic [15:0] mem_addr;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_write;
    logic        reg_read;
    wire         reset_indicator_n_i;
    wire         reset_indicator_n_o;
    wire         reset_indicator_n_oe;
    wire         backup_active_n;
    wire         switched_memory_supply_bk;
    wire         core_reset;
    wire         warn_irq;
    wire  [7:0]  warn_vector;
    wire  [3:0]  memory_bank_select_n;
    wire  [3:0]  io_device_select_n;
    wire         sram_write_n;
    wire  [15:0] bytewide_addr;
    wire         expanded_bus_sel;
    wire  [15:0] expanded_addr;
    wire  [7:0]  reg_rdata;
    int          n_mismatch;
    int          total_checks;
    int          hits;

    pmms_top dut (.*);
    pmms_partner u_far (
        .dev_o    (reset_indicator_n_o),
        .dev_oe   (reset_indicator_n_oe),
        .ext_pull (ext_pull),
        .line_n   (reset_indicator_n_i)
    );

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, e});
    endtask

    // Result packs bank selects, peripheral selects, write strobe, expanded flag.
    task acc(input logic d, input logic w, input logic [15:0] a, input logic [15:0] e);
        @(posedge clock);
        mem_req     <= 1'b1;
        mem_is_data <= d;
        mem_write   <= w;
        mem_addr    <= a;
        @(posedge clock);
        mem_req <= 1'b0;
        #1;
        chk({memory_bank_select_n, io_device_select_n, 3'h0, sram_write_n,
             3'h0, expanded_bus_sel}, e);
    endtask

    initial
    begin
        #400000;
        n_mismatch++;
        finish_test;
    end

    initial
    begin
        srst = 1'b1;
        below_warning = 1'b0;
        below_reset = 1'b0;
        below_backup = 1'b0;
        sram_size_select = 1'b1;
        ext_pull = 1'b0;
        mem_req = 1'b0;
        mem_is_data = 1'b0;
        mem_write = 1'b0;
        mem_addr = 16'h0000;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        wt(4);
        rd(3'h1, 8'h10);
        rd(3'h2, 8'h10);
        rd(3'h3, 8'h08);
        rd(3'h5, 8'h00);
        acc(1'b1, 1'b1, 16'h1234, 16'hbf00);
        chk(bytewide_addr, 16'h1234);
        acc(1'b0, 1'b1, 16'h8000, 16'hdf10);
        wr(3'h1, 8'h04);
        acc(1'b0, 1'b0, 16'h5000, 16'hff11);
        chk(expanded_addr, 16'h5000);
        acc(1'b0, 1'b0, 16'h3000, 16'hef10);
        wr(3'h0, 8'h02);
        acc(1'b0, 1'b0, 16'h7000, 16'hef10);
        acc(1'b1, 1'b1, 16'h9000, 16'hdf00);
        acc(1'b0, 1'b0, 16'h9000, 16'hff11);
        wr(3'h0, 8'h04);
        for (int q = 0; q < 4; q++)
            acc(1'b1, 1'b0, {q[1:0], 14'h0123}, {4'hf, ~(4'h1 << q), 8'h10});
        $display("test decode done");
        @(posedge clock);
        sram_size_select <= 1'b0;
        wr(3'h0, 8'h00);
        wt(4);
        acc(1'b1, 1'b1, 16'h9234, 16'hef00);
        acc(1'b0, 1'b0, 16'h1234, 16'h8f10);
        @(posedge clock);
        sram_size_select <= 1'b1;
        wr(3'h0, 8'h01);
        wt(4);
        $display("test size done");
        @(posedge clock);
        below_warning <= 1'b1;
        hits = 0;
        for (int i = 0; i < 8; i++)
        begin
            wt(1);
            if (warn_irq === 1'b1)
                hits++;
        end
        chk(hits[15:0], 16'h1);
        chk({8'h00, warn_vector}, 16'h2b);
        rd(3'h4, 8'h13);
        wr(3'h4, 8'h01);
        rd(3'h4, 8'h12);
        @(posedge clock);
        below_warning <= 1'b0;
        $display("test warning done");
        @(posedge clock);
        below_reset <= 1'b1;
        wt(3);
        chk({14'h0, core_reset, reset_indicator_n_i}, 16'h2);
        acc(1'b1, 1'b1, 16'h1234, 16'hff10);
        @(posedge clock);
        below_reset <= 1'b0;
        wt(5);
        chk({15'h0, core_reset}, 16'h0);
        @(posedge clock);
        ext_pull <= 1'b1;
        wt(5);
        chk({15'h0, core_reset}, 16'h1);
        @(posedge clock);
        ext_pull <= 1'b0;
        wt(5);
        rd(3'h4, 8'h30);
        $display("test reset done");
        @(posedge clock);
        below_backup <= 1'b1;
        wt(5);
        chk({backup_active_n, switched_memory_supply_bk, core_reset}, 16'h3);
        acc(1'b0, 1'b0, 16'h0100, 16'hff10);
        @(posedge clock);
        below_backup <= 1'b0;
        wt(5);
        chk({15'h0, backup_active_n}, 16'h1);
        $display("test backup done");
        finish_test;
    end
endmodule
